// ===== dv/rail_sequencer_timing_control_tb.sv
// Self-checking bench for the rail sequencer
module rail_sequencer_timing_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int MS = 10;
  localparam int NR = rsq_pkg::NUM_RAILS;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  rsq_pkg::rsq_reg_req_t reg_req;
  logic cfg_unlocked;
  logic [7:0] reg_rdata;
  logic pin = 1'b1;
  rsq_pkg::rsq_codes_t codes = '0;
  logic [NR-1:0] direct = '0;
  logic [NR-1:0] rail_en;
  logic seq_busy;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int t_on[NR];
  int t_off[NR];
  int ms_tab[4] = '{1, 2, 5, 10};
  logic [NR-1:0] prev = '0;
  logic [31:0] lfsr = 32'hf393cd8f;
  logic [7:0] e;
  logic [7:0] l;
  logic [7:0] d;

  always #5 core_clk = ~core_clk;

  rsq_sequencer #(.MS_CYCLES(MS)) dut (
    .core_clk(core_clk), .nrst(nrst), .reg_req(reg_req),
    .cfg_unlocked(cfg_unlocked), .reg_rdata(reg_rdata),
    .ext_power_enable_pin(pin), .rail_slot_code(codes),
    .rail_direct_en(direct), .rail_en(rail_en), .seq_busy(seq_busy)
  );

  rsq_host_model host (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_req(reg_req),
    .cfg_unlocked(cfg_unlocked)
  );

  // Edge log of every rail, in core clock cycles
  always @(posedge core_clk) begin
    cyc++;
    for (int i = 0; i < NR; i++) begin
      if (rail_en[i] !== prev[i]) begin
        if (rail_en[i] === 1'b1) t_on[i] = cyc;
        else t_off[i] = cyc;
      end
    end
    prev = rail_en;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // Expected wait of slot n in ms, slots five and above use the late fields
  function automatic int exp_ms(input int n);
    logic [1:0] c;
    if (n < 5) c = 2'(e >> (8 - 2 * n));
    else if (n == 5) c = l[7:6];
    else c = l[5:4];
    return ms_tab[c];
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    host.rd(a, d);
    chk("register", {24'h0, ex}, {24'h0, d});
  endtask

  // Wait out a sequence; a hang shows up as busy still high
  task automatic settle;
    for (int i = 0; i < 3000 && seq_busy !== 1'b0; i++) @(posedge core_clk);
    chk("busy", 32'h0, {31'h0, seq_busy});
  endtask

  task automatic run(input logic [7:0] v);
    host.wr(8'h1e, v);
    repeat (3) @(posedge core_clk);
    settle;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Six sequences of at most about 1500 cycles each, with ample margin
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    tally_and_finish;
  end

  initial begin
    for (int i = 0; i < 6; i++) codes[i] = 4'(i + 1);
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    // ************************************************
    // Registers: reset values, unmapped, lock
    // ************************************************
    rd_chk(8'h1d, 8'h20);
    rd_chk(8'h1e, 8'h00);
    rd_chk(8'h55, 8'h00);
    host.wr(8'h1d, 8'hff);
    rd_chk(8'h1d, 8'h20);
    host.unlock(1'b1);
    lfsr = nxt(lfsr);
    e = lfsr[7:0];
    l = {lfsr[15:12], 4'h0};
    @(posedge core_clk);
    direct <= {lfsr[16], 6'h0};
    host.wr(8'h1d, e);
    rd_chk(8'h1d, e);
    $display("test registers done");
    // ************************************************
    // Power-up walks slots upward with selected waits
    // ************************************************
    run(l | 8'h04);
    rd_chk(8'h1e, l);
    chk("rails up", {25'h0, direct[6], 6'h3f}, {25'h0, rail_en});
    for (int n = 1; n < 6; n++)
      chk("up gap", exp_ms(n) * MS + 3, t_on[n] - t_on[n - 1]);
    $display("test power up done");
    // ************************************************
    // Ordered power-down in reverse slot order, by bit then by pin
    // ************************************************
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        run(l | 8'h02);
      end else begin
        run(l | 8'h04);
        @(posedge core_clk);
        pin <= 1'b0;
        // Two sync stages and the edge detect pass before busy rises
        repeat (4) @(posedge core_clk);
        settle;
      end
      rd_chk(8'h1e, l);
      chk("rails down", {25'h0, direct[6], 6'h0}, {25'h0, rail_en});
      for (int n = 5; n > 0; n--)
        chk("dn gap", exp_ms(n) * MS + 3, t_off[n - 1] - t_off[n]);
      pin <= 1'b1;
      $display("test ordered down %0d done", k);
    end
    // ************************************************
    // Instant shutdown by pin, then by trigger bit
    // ************************************************
    for (int k = 0; k < 2; k++) begin
      run(l | 8'h04);
      if (k == 0) begin
        host.wr(8'h1e, l | 8'h01);
        @(posedge core_clk);
        pin <= 1'b0;
      end else begin
        host.wr(8'h1e, l | 8'h03);
      end
      repeat (8) @(posedge core_clk);
      chk("rails off", {25'h0, direct[6], 6'h0}, {25'h0, rail_en});
      for (int i = 1; i < 6; i++)
        chk("same drop", t_off[0], t_off[i]);
      pin <= 1'b1;
      $display("test instant down %0d done", k);
    end
    tally_and_finish;
  end
endmodule

// ===== dv/rsq_host_model.sv
// Host model: drives the sequencer register port as a host would
module rsq_host_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output rsq_pkg::rsq_reg_req_t reg_req,
  output logic cfg_unlocked
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_req = '0;
    cfg_unlocked = 1'b0;
  end

  // Config writes only count once the host has unlocked
  task automatic unlock(input logic on);
    @(posedge core_clk);
    cfg_unlocked <= on;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    // A released bus shows the inverse, never a stale copy
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~a};
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: a};
    @(posedge core_clk);
    d = reg_rdata;
  endtask
endmodule

// ===== hw/rsq_pkg.sv
// Constants, types and helpers shared by the rail sequencer files
package rsq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_EARLY = 8'h1d;
  localparam logic [7:0] ADDR_LATE = 8'h1e;
  localparam logic [7:0] EARLY_RST = 8'h20;
  localparam logic [1:0] WAIT5_RST = 2'h0;
  localparam logic [1:0] WAIT6_RST = 2'h0;
  localparam int POS_W1 = 6;
  localparam int POS_W2 = 4;
  localparam int POS_W3 = 2;
  localparam int POS_W4 = 0;
  localparam int POS_W5 = 6;
  localparam int POS_W6 = 4;
  localparam int POS_UP = 2;
  localparam int POS_DN = 1;
  localparam int POS_INST = 0;

  // ****************************************************************
  // Slots and timing
  // ****************************************************************
  localparam int unsigned NUM_RAILS = 7;
  localparam logic [3:0] SLOT_NONE = 4'h0;
  localparam logic [3:0] SLOT_FIRST = 4'h1;
  localparam logic [3:0] SLOT_LAST = 4'hf;
  localparam logic [3:0] MS_CODE0 = 4'h1;
  localparam logic [3:0] MS_CODE1 = 4'h2;
  localparam logic [3:0] MS_CODE2 = 4'h5;
  localparam logic [3:0] MS_CODE3 = 4'ha;
  localparam int unsigned MS_UNIT_NS = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_CYCLES = MS_UNIT_NS / CLK_PERIOD_NS;
  localparam int PRESC_W = 24;
  localparam logic SYNC_RST = 1'b1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_UP_SLOT,
    ST_UP_WAIT,
    ST_DN_SLOT,
    ST_DN_WAIT
  } rsq_st_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsq_reg_req_t;

  typedef logic [NUM_RAILS-1:0][3:0] rsq_codes_t;

  typedef struct packed {
    logic [7:0] early;
    logic [1:0] wait5;
    logic [1:0] wait6;
    logic up_trig;
    logic down_trig;
    logic instant;
    logic en_s1;
    logic en_s2;
    logic en_s3;
    rsq_st_t st;
    logic [3:0] slot;
    logic tmr_start;
    logic [3:0] tmr_ms;
    logic busy;
    logic [NUM_RAILS-1:0] rail_en;
    logic [7:0] rdata;
  } rsq_state_t;

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic [3:0] ms_left;
    logic run;
    logic done;
  } rsq_tmr_t;

  function automatic logic [3:0] wait_ms(input logic [1:0] code);
    logic [3:0] ms;
    ms = MS_CODE0;
    unique case (code)
      2'h0: ms = MS_CODE0;
      2'h1: ms = MS_CODE1;
      2'h2: ms = MS_CODE2;
      2'h3: ms = MS_CODE3;
    endcase
    return ms;
  endfunction

endpackage

// ===== hw/rsq_sequencer.sv
// Rail sequencer: slot timing, power-up and power-down control
module rsq_sequencer #(
  parameter int unsigned MS_CYCLES = rsq_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input rsq_pkg::rsq_reg_req_t reg_req,
  input wire logic cfg_unlocked,
  output logic [7:0] reg_rdata,
  input wire logic ext_power_enable_pin,
  input rsq_pkg::rsq_codes_t rail_slot_code,
  input wire logic [rsq_pkg::NUM_RAILS-1:0] rail_direct_en,
  output logic [rsq_pkg::NUM_RAILS-1:0] rail_en,
  output logic seq_busy
);

  // ****************************************************************
  // State
  // ****************************************************************
  rsq_pkg::rsq_state_t s;
  rsq_pkg::rsq_state_t nxt;
  logic tmr_done;
  logic early_wr;
  logic late_wr;
  logic pin_fall;
  logic down_req;
  logic [rsq_pkg::NUM_RAILS-1:0] seq_mask;

  function automatic logic [1:0] gap_code(input rsq_pkg::rsq_state_t st,
                                          input logic [3:0] gap);
    logic [1:0] c;
    c = st.wait6;
    unique case (gap)
      4'h1: c = st.early[rsq_pkg::POS_W1 +: 2];
      4'h2: c = st.early[rsq_pkg::POS_W2 +: 2];
      4'h3: c = st.early[rsq_pkg::POS_W3 +: 2];
      4'h4: c = st.early[rsq_pkg::POS_W4 +: 2];
      4'h5: c = st.wait5;
      default: c = st.wait6;
    endcase
    return c;
  endfunction

  // Writes only land while the password logic reports unlocked
  assign early_wr = reg_req.wr && cfg_unlocked &&
                    reg_req.addr == rsq_pkg::ADDR_EARLY;
  assign late_wr = reg_req.wr && cfg_unlocked &&
                   reg_req.addr == rsq_pkg::ADDR_LATE;
  // Read only behind the second synchroniser stage
  assign pin_fall = s.en_s3 && !s.en_s2;
  assign down_req = s.down_trig || pin_fall;

  always_comb begin
    for (int i = 0; i < rsq_pkg::NUM_RAILS; i++) begin
      seq_mask[i] = rail_slot_code[i] != rsq_pkg::SLOT_NONE;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic hit_on;
    logic hit_off;
    logic all_off;
    hit_on = 1'b0;
    hit_off = 1'b0;
    all_off = 1'b0;
    nxt = s;
    nxt.tmr_start = 1'b0;
    nxt.en_s1 = ext_power_enable_pin;
    nxt.en_s2 = s.en_s1;
    nxt.en_s3 = s.en_s2;

    // Triggers clear the cycle after they are seen; a new write wins
    nxt.up_trig = 1'b0;
    nxt.down_trig = 1'b0;
    if (early_wr) begin
      nxt.early = reg_req.wdata;
    end
    if (late_wr) begin
      nxt.wait5 = reg_req.wdata[rsq_pkg::POS_W5 +: 2];
      nxt.wait6 = reg_req.wdata[rsq_pkg::POS_W6 +: 2];
      nxt.up_trig = reg_req.wdata[rsq_pkg::POS_UP];
      nxt.down_trig = reg_req.wdata[rsq_pkg::POS_DN];
      nxt.instant = reg_req.wdata[rsq_pkg::POS_INST];
    end

    // Power-down preempts idle and power-up, not a running power-down; power-up only starts from idle
    if (down_req && s.st != rsq_pkg::ST_DN_SLOT &&
        s.st != rsq_pkg::ST_DN_WAIT) begin
      if (s.instant) begin
        all_off = 1'b1;
        nxt.st = rsq_pkg::ST_IDLE;
      end else begin
        nxt.slot = rsq_pkg::SLOT_LAST;
        nxt.st = rsq_pkg::ST_DN_SLOT;
      end
    end else begin
      unique case (s.st)
        rsq_pkg::ST_IDLE: begin
          if (s.up_trig) begin
            nxt.slot = rsq_pkg::SLOT_FIRST;
            nxt.st = rsq_pkg::ST_UP_SLOT;
          end
        end
        rsq_pkg::ST_UP_SLOT: begin
          hit_on = 1'b1;
          if (s.slot == rsq_pkg::SLOT_LAST) begin
            nxt.st = rsq_pkg::ST_IDLE;
          end else begin
            nxt.tmr_ms = rsq_pkg::wait_ms(gap_code(s, s.slot));
            nxt.tmr_start = 1'b1;
            nxt.st = rsq_pkg::ST_UP_WAIT;
          end
        end
        rsq_pkg::ST_UP_WAIT: begin
          // Ignore a pulse that belongs to a wait just restarted
          if (tmr_done && !s.tmr_start) begin
            nxt.slot = s.slot + 4'h1;
            nxt.st = rsq_pkg::ST_UP_SLOT;
          end
        end
        rsq_pkg::ST_DN_SLOT: begin
          hit_off = 1'b1;
          if (s.slot == rsq_pkg::SLOT_FIRST) begin
            nxt.st = rsq_pkg::ST_IDLE;
          end else begin
            nxt.tmr_ms =
              rsq_pkg::wait_ms(gap_code(s, s.slot - 4'h1));
            nxt.tmr_start = 1'b1;
            nxt.st = rsq_pkg::ST_DN_WAIT;
          end
        end
        rsq_pkg::ST_DN_WAIT: begin
          if (tmr_done && !s.tmr_start) begin
            nxt.slot = s.slot - 4'h1;
            nxt.st = rsq_pkg::ST_DN_SLOT;
          end
        end
      endcase
    end
    nxt.busy = nxt.st != rsq_pkg::ST_IDLE;

    for (int i = 0; i < rsq_pkg::NUM_RAILS; i++) begin
      if (!seq_mask[i]) begin
        nxt.rail_en[i] = rail_direct_en[i];
      end else if (all_off) begin
        nxt.rail_en[i] = 1'b0;
      end else if (hit_on && rail_slot_code[i] == s.slot) begin
        nxt.rail_en[i] = 1'b1;
      end else if (hit_off && rail_slot_code[i] == s.slot) begin
        nxt.rail_en[i] = 1'b0;
      end
    end

    // Unmapped addresses read as zero; the unused bit 3 reads zero
    nxt.rdata = s.rdata;
    if (reg_req.rd) begin
      if (reg_req.addr == rsq_pkg::ADDR_EARLY) begin
        nxt.rdata = s.early;
      end else if (reg_req.addr == rsq_pkg::ADDR_LATE) begin
        nxt.rdata = {s.wait5, s.wait6, 1'b0, s.up_trig, s.down_trig,
                     s.instant};
      end else begin
        nxt.rdata = 8'h00;
      end
    end
  end

  // ****************************************************************
  // Registers and timer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.early <= rsq_pkg::EARLY_RST;
      s.wait5 <= rsq_pkg::WAIT5_RST;
      s.wait6 <= rsq_pkg::WAIT6_RST;
      s.en_s1 <= rsq_pkg::SYNC_RST;
      s.en_s2 <= rsq_pkg::SYNC_RST;
      s.en_s3 <= rsq_pkg::SYNC_RST;
      s.st <= rsq_pkg::ST_IDLE;
    end else begin
      s <= nxt;
    end
  end

  rsq_slot_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(s.tmr_start),
    .ms(s.tmr_ms),
    .done(tmr_done)
  );

  assign reg_rdata = s.rdata;
  assign rail_en = s.rail_en;
  assign seq_busy = s.busy;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Every code is checked, but only for slot 1, so only a random early[7:6] exercises the map
  property p_wait_map;
    s.tmr_start && s.st == rsq_pkg::ST_UP_WAIT && s.slot == 4'h1 |->
      (s.early[7:6] == 2'h0 && s.tmr_ms == 4'h1) ||
      (s.early[7:6] == 2'h1 && s.tmr_ms == 4'h2) ||
      (s.early[7:6] == 2'h2 && s.tmr_ms == 4'h5) ||
      (s.early[7:6] == 2'h3 && s.tmr_ms == 4'ha);
  endproperty
  a_wait_map: assert property (p_wait_map)
    else $error("slot wait code did not give 1, 2, 5 or 10 ms");

  property p_locked;
    reg_req.wr && !cfg_unlocked |=> s.early == $past(s.early) &&
      s.wait5 == $past(s.wait5) && s.instant == $past(s.instant);
  endproperty
  a_locked: assert property (p_locked)
    else $error("write landed while the registers were locked");

  property p_late_fields;
    late_wr |=> s.wait5 == $past(reg_req.wdata[7:6]) &&
      s.wait6 == $past(reg_req.wdata[5:4]);
  endproperty
  a_late_fields: assert property (p_late_fields)
    else $error("late slot waits not stored from bits 7:4");

  property p_up_start;
    s.st == rsq_pkg::ST_IDLE && s.up_trig && !down_req |=>
      s.st == rsq_pkg::ST_UP_SLOT && s.slot == 4'h1;
  endproperty
  a_up_start: assert property (p_up_start)
    else $error("power-up trigger did not start at slot 1");

  property p_selfclear;
    late_wr && reg_req.wdata[2] |=> s.up_trig ##1
      (!s.up_trig || $past(late_wr));
  endproperty
  a_selfclear: assert property (p_selfclear)
    else $error("power-up trigger did not clear itself");

  property p_dn_start;
    s.st == rsq_pkg::ST_IDLE && s.down_trig && !s.instant |=>
      s.st == rsq_pkg::ST_DN_SLOT && s.slot == 4'hf;
  endproperty
  a_dn_start: assert property (p_dn_start)
    else $error("power-down trigger did not start at slot 15");

  property p_reverse;
    s.st == rsq_pkg::ST_DN_WAIT && tmr_done && !s.tmr_start |=>
      s.st == rsq_pkg::ST_DN_SLOT && s.slot == $past(s.slot) - 4'h1;
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("power-down did not step one slot down");

  property p_instant;
    down_req && s.instant && s.st == rsq_pkg::ST_IDLE |=>
      (s.rail_en & $past(seq_mask)) == '0 && s.st == rsq_pkg::ST_IDLE;
  endproperty
  a_instant: assert property (p_instant)
    else $error("instant shutdown left a sequenced rail on");

  property p_pin_fall;
    $fell(s.en_s2) && !s.instant && s.st == rsq_pkg::ST_IDLE |=>
      s.st == rsq_pkg::ST_DN_SLOT && s.slot == 4'hf;
  endproperty
  a_pin_fall: assert property (p_pin_fall)
    else $error("enable pin low did not start shutdown");

  property p_unseq;
    1'b1 |=> (s.rail_en & ~$past(seq_mask)) ==
      ($past(rail_direct_en) & ~$past(seq_mask));
  endproperty
  a_unseq: assert property (p_unseq)
    else $error("rail outside the sequencer was changed");

  property p_hold_slot;
    s.st == rsq_pkg::ST_UP_WAIT && !tmr_done && !down_req |=>
      s.slot == $past(s.slot) && s.st == rsq_pkg::ST_UP_WAIT;
  endproperty
  a_hold_slot: assert property (p_hold_slot)
    else $error("power-up advanced before its wait ended");

  property p_dn_hold;
    s.st == rsq_pkg::ST_DN_WAIT && !tmr_done |=>
      s.slot == $past(s.slot) && s.st == rsq_pkg::ST_DN_WAIT;
  endproperty
  a_dn_hold: assert property (p_dn_hold)
    else $error("power-down advanced before its wait ended");

  c_up_done: cover property (s.st == rsq_pkg::ST_UP_SLOT &&
    s.slot == 4'hf ##1 s.st == rsq_pkg::ST_IDLE);
  c_instant: cover property (down_req && s.instant);
  c_pin_down: cover property (pin_fall ##1 s.st == rsq_pkg::ST_DN_SLOT);
  c_preempt: cover property (s.st == rsq_pkg::ST_UP_WAIT && down_req);

endmodule

// ===== hw/rsq_slot_timer.sv
// Millisecond slot timer: counts a number of 1 ms periods, then pulses
module rsq_slot_timer #(
  parameter int unsigned MS_CYCLES = rsq_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [3:0] ms,
  output logic done
);

  localparam logic [rsq_pkg::PRESC_W-1:0] RELOAD =
    rsq_pkg::PRESC_W'(MS_CYCLES - 1);

  rsq_pkg::rsq_tmr_t t_r;
  rsq_pkg::rsq_tmr_t t_nxt;

  // A new start reloads the count; an aborted wait not restarted still pulses, and a due pulse shows while start is high
  always_comb begin
    t_nxt = t_r;
    t_nxt.done = 1'b0;
    if (start) begin
      t_nxt.run = 1'b1;
      t_nxt.ms_left = ms;
      t_nxt.presc = RELOAD;
    end else if (t_r.run) begin
      if (t_r.presc == '0) begin
        if (t_r.ms_left <= 4'h1) begin
          t_nxt.run = 1'b0;
          t_nxt.done = 1'b1;
        end else begin
          t_nxt.ms_left = t_r.ms_left - 4'h1;
          t_nxt.presc = RELOAD;
        end
      end else begin
        t_nxt.presc = t_r.presc - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign done = t_r.done;

endmodule
